// file: pkg/flash_port_pkg.sv
// Constants, states and helpers for the flash-side slow port sequencer.
// Assumes a 25 MHz system clock and external glue that latches the address.
package flash_port_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 26;
    localparam int REGION_BIT = 25;
    localparam int BYTE_W = 8;
    localparam logic [2:0] ADDR_BYTES_LAST = 3'h2;
    localparam logic [2:0] STROBE_LAST = 3'h3;
    localparam logic [1:0] SEL_IDLE_N = 2'h3;
    localparam logic [1:0] SEL_FLASH_N = 2'h2;
    localparam logic [1:0] SEL_PROC_N = 2'h1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [25:0] ADDR_RESET = 26'h0000000;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_SETUP = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD = 5'h10
    } seq_state_t;

    // Byte idx of the upper address field A[25:2], idx 0 least significant
    function automatic logic [7:0] addr_byte(input logic [25:0] addr,
                                             input logic [2:0] idx);
        logic [23:0] upper;
        upper = addr[25:2];
        case (idx)
            3'h0: addr_byte = upper[7:0];
            3'h1: addr_byte = upper[15:8];
            default: addr_byte = upper[23:16];
        endcase
    endfunction

    function automatic logic [1:0] region_sel_n(input logic [25:0] addr);
        region_sel_n = addr[REGION_BIT] ? SEL_PROC_N : SEL_FLASH_N;
    endfunction

endpackage

// file: rtl/port_clock_div.sv
// Divides the system clock by two to form the outgoing port clock.
// Assumes the consumer changes its pins on the tick edge.
`timescale 1ns/1ns
module port_clock_div
    import flash_port_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Port clock and advance tick
    output logic port_clk_out,
    output logic fall_tick_out
);

    logic clk_q;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            clk_q <= 1'b0;
        end
        else
        begin
            clk_q <= ~clk_q;
        end
    end

    // Pins change as the port clock falls, so the glue sees a full half
    // period of setup before its rising edge
    assign port_clk_out = clk_q;
    assign fall_tick_out = clk_q;

endmodule // port_clock_div

// file: rtl/slow_port_flash.sv
// Flash-side slow port sequencer: shifts the address out, then moves a byte.
// Assumes a same-clock requester and external glue latching the address.
`timescale 1ns/1ns
module slow_port_flash
    import flash_port_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // Request side
    input wire logic REQ_VALID_IN,
    input wire logic REQ_WRITE_IN,
    input wire logic [25:0] REQ_ADDR_IN,
    input wire logic [7:0] REQ_WDATA_IN,
    output logic REQ_READY_OUT,
    // Answer side
    output logic RSP_VALID_OUT,
    output logic [7:0] RSP_RDATA_OUT,
    // Port pins
    output logic PORT_CLOCK_OUT,
    output logic [1:0] REGION_SELECT_N_OUT,
    output logic ADDR_LATCH_STROBE_N_OUT,
    input wire logic [7:0] MUXED_ADDR_DATA_IN,
    output logic [7:0] MUXED_ADDR_DATA_OUT,
    output logic MUXED_ADDR_DATA_OE_OUT,
    output logic XFER_DIRECTION_OUT,
    output logic PACK_STROBE_OUT,
    output logic READ_STROBE_N_OUT,
    output logic WRITE_STROBE_N_OUT
);

    seq_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [25:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic we_q, we_d;
    logic ready_q;
    logic tick;
    logic take;
    logic [7:0] bus_meta_q, bus_sync_q;

    ////////////////////////////////////////////////////////////////////////
    port_clock_div u_div (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .port_clk_out(PORT_CLOCK_OUT),
        .fall_tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Ready is only high in tick cycles, so a take always starts a port cycle
    assign take = REQ_VALID_IN && ready_q;

    always_comb
    begin
        addr_d = take ? REQ_ADDR_IN : addr_q;
        wdata_d = take ? REQ_WDATA_IN : wdata_q;
        we_d = take ? REQ_WRITE_IN : we_q;
        state_d = state_q;
        cnt_d = cnt_q;
        if (tick)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        state_d = ST_ADDR;
                        cnt_d = 3'h0;
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_q == ADDR_BYTES_LAST)
                    begin
                        state_d = ST_SETUP;
                        cnt_d = 3'h0;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
                ST_SETUP:
                begin
                    state_d = ST_STROBE;
                    cnt_d = 3'h0;
                end
                ST_STROBE:
                begin
                    if (cnt_q == STROBE_LAST)
                    begin
                        state_d = ST_HOLD;
                        cnt_d = 3'h0;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
                ST_HOLD:
                begin
                    state_d = ST_IDLE;
                end
                default:
                begin
                    state_d = ST_IDLE;
                    cnt_d = 3'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            addr_q <= ADDR_RESET;
            wdata_q <= DATA_RESET;
            we_q <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
            ready_q <= (state_d == ST_IDLE) && !tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs other than the port clock are all registered from the next state
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            REGION_SELECT_N_OUT <= SEL_IDLE_N;
            ADDR_LATCH_STROBE_N_OUT <= 1'b1;
            MUXED_ADDR_DATA_OUT <= DATA_RESET;
            MUXED_ADDR_DATA_OE_OUT <= 1'b0;
            XFER_DIRECTION_OUT <= 1'b0;
            PACK_STROBE_OUT <= 1'b0;
            READ_STROBE_N_OUT <= 1'b1;
            WRITE_STROBE_N_OUT <= 1'b1;
        end
        else
        begin
            REGION_SELECT_N_OUT <= (state_d == ST_IDLE) ? SEL_IDLE_N
                                   : region_sel_n(addr_d);
            ADDR_LATCH_STROBE_N_OUT <= (state_d != ST_ADDR);
            MUXED_ADDR_DATA_OUT <= (state_d == ST_ADDR)
                                   ? addr_byte(addr_d, cnt_d)
                                   : wdata_d;
            // Bus turns round to input for reads once the address is out
            MUXED_ADDR_DATA_OE_OUT <= (state_d == ST_ADDR) ||
                                      (we_d && (state_d != ST_IDLE));
            // Low address bits ride their own pins
            XFER_DIRECTION_OUT <= (state_d != ST_IDLE)
                                  && addr_d[1];
            PACK_STROBE_OUT <= (state_d != ST_IDLE) && addr_d[0];
            READ_STROBE_N_OUT <= !((state_d == ST_STROBE) && !we_d);
            WRITE_STROBE_N_OUT <= !((state_d == ST_STROBE) && we_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin data is asynchronous to us; two flops before anything samples it
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            bus_meta_q <= DATA_RESET;
            bus_sync_q <= DATA_RESET;
        end
        else
        begin
            bus_meta_q <= MUXED_ADDR_DATA_IN;
            bus_sync_q <= bus_meta_q;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            RSP_RDATA_OUT <= DATA_RESET;
            RSP_VALID_OUT <= 1'b0;
            REQ_READY_OUT <= 1'b0;
        end
        else
        begin
            // Sampled late in the strobe to absorb synchroniser lag
            if (tick && (state_q == ST_STROBE) && (cnt_q == STROBE_LAST)
                && !we_q)
            begin
                RSP_RDATA_OUT <= bus_sync_q;
            end
            RSP_VALID_OUT <= tick && (state_q == ST_HOLD);
            REQ_READY_OUT <= (state_d == ST_IDLE) && !tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_ONE_REGION: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        REGION_SELECT_N_OUT != 2'h0)
        else $error("both region selects asserted");

    AST_REGION_DECODE: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (REGION_SELECT_N_OUT != SEL_IDLE_N) |->
        (REGION_SELECT_N_OUT[0] == addr_q[REGION_BIT]))
        else $error("region select does not match address");

    AST_ADDR_THREE_CYCLES: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        $fell(ADDR_LATCH_STROBE_N_OUT) |->
        (!ADDR_LATCH_STROBE_N_OUT)[*6] ##1 ADDR_LATCH_STROBE_N_OUT)
        else $error("latch strobe not low for three port clocks");

    AST_BYTE_ORDER: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        $fell(ADDR_LATCH_STROBE_N_OUT) |->
        (MUXED_ADDR_DATA_OUT == addr_q[9:2]) ##2
        (MUXED_ADDR_DATA_OUT == addr_q[17:10]) ##2
        (MUXED_ADDR_DATA_OUT == addr_q[25:18]))
        else $error("address bytes out of order");

    AST_WRITE_BYTE: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        !WRITE_STROBE_N_OUT |->
        (MUXED_ADDR_DATA_OE_OUT && MUXED_ADDR_DATA_OUT == wdata_q))
        else $error("write byte not driven during write strobe");

    AST_READ_TURNROUND: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        !READ_STROBE_N_OUT |-> !MUXED_ADDR_DATA_OE_OUT)
        else $error("bus driven during read strobe");

    AST_DIR_BIT: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (REGION_SELECT_N_OUT != SEL_IDLE_N) |->
        (XFER_DIRECTION_OUT == addr_q[1]))
        else $error("direction output is not address bit 1");

    AST_PACK_BIT: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (REGION_SELECT_N_OUT != SEL_IDLE_N) |->
        (PACK_STROBE_OUT == addr_q[0]))
        else $error("pack strobe is not address bit 0");

    AST_LOW_BITS_STEADY: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        !ADDR_LATCH_STROBE_N_OUT && !$fell(ADDR_LATCH_STROBE_N_OUT) |->
        $stable(XFER_DIRECTION_OUT) && $stable(PACK_STROBE_OUT))
        else $error("low address bits changed during latch phase");

    AST_STROBE_LEN: assert property (
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        $fell(READ_STROBE_N_OUT) |->
        (!READ_STROBE_N_OUT)[*8] ##1 READ_STROBE_N_OUT ##2 RSP_VALID_OUT)
        else $error("read strobe length or answer timing wrong");

endmodule // slow_port_flash

// file: tb/flash_glue_model.sv
// Far-side model: the glue address latch plus one 8-bit flash behind it.
// Assumes the bench resolves the shared bus from the sequencer's output enable alone.
`timescale 1ns/1ns
module flash_glue_model (
    // Port pins
    input wire logic port_clk_in,
    input wire logic glue_rstn_in,
    input wire logic [1:0] sel_n_in,
    input wire logic ale_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] bus_in,
    // Model side
    output logic [7:0] drive_out,
    output logic [23:0] addr_out,
    output logic [2:0] ale_count_out,
    output logic [7:0] wdata_out
);
    logic [2:0] idx_q;
    logic [7:0] last_q;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge port_clk_in)
    begin
        last_q <= bus_in;
        if (!glue_rstn_in)
        begin
            addr_out <= 24'h000000;
            idx_q <= 3'h0;
            ale_count_out <= 3'h0;
        end
        else if (!ale_n_in)
        begin
            // Index wraps, so a fourth byte falls beyond addr_out and a fifth would corrupt the low byte
            addr_out[{idx_q[1:0], 3'h0} +: 8] <= bus_in;
            idx_q <= idx_q + 3'h1;
        end
        else if (idx_q != 3'h0)
        begin
            ale_count_out <= idx_q;
            idx_q <= 3'h0;
        end
    end

    // Byte taken whole as the strobe ends; nothing else is needed
    always @(posedge wr_n_in)
    begin
        wdata_out <= bus_in;
    end

    // Flash answers only in its own region; a released bus shows ~last
    assign drive_out = (!rd_n_in && !sel_n_in[0]) ?
        (addr_out[7:0] ^ 8'h5a) : ~last_q;
endmodule // flash_glue_model

// file: tb/slow_port_flash_addr_latch_bench.sv
// Bench for the flash-side slow port sequencer with a glue latch model.
// Assumes the 18-cycle answer and ready handshake of the sequencer.
`timescale 1ns/1ns
module slow_port_flash_addr_latch_bench;
    import flash_port_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic glue_rstn = 1'b0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic [25:0] addr = 26'h0000000;
    logic [7:0] wdata = 8'h00;
    logic ready, rsp, pclk, ale_n, oe, dir, pack, rd_n, wr_n;
    logic [1:0] sel_n;
    logic [7:0] rdata, dout, drive, bus, gwd;
    logic [23:0] gaddr;
    logic [2:0] gcnt;
    int mismatches = 0;
    int num_checks = 0;

    always #20 clk = ~clk;
    assign bus = oe ? dout : drive;

    slow_port_flash dut (.CLK_IN(clk), .RESETN_IN(rstn),
        .REQ_VALID_IN(valid), .REQ_WRITE_IN(wr), .REQ_ADDR_IN(addr),
        .REQ_WDATA_IN(wdata), .REQ_READY_OUT(ready), .RSP_VALID_OUT(rsp),
        .RSP_RDATA_OUT(rdata), .PORT_CLOCK_OUT(pclk),
        .REGION_SELECT_N_OUT(sel_n), .ADDR_LATCH_STROBE_N_OUT(ale_n),
        .MUXED_ADDR_DATA_IN(bus), .MUXED_ADDR_DATA_OUT(dout),
        .MUXED_ADDR_DATA_OE_OUT(oe), .XFER_DIRECTION_OUT(dir),
        .PACK_STROBE_OUT(pack), .READ_STROBE_N_OUT(rd_n),
        .WRITE_STROBE_N_OUT(wr_n));

    flash_glue_model glue (.port_clk_in(pclk), .glue_rstn_in(glue_rstn),
        .sel_n_in(sel_n), .ale_n_in(ale_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .bus_in(bus), .drive_out(drive), .addr_out(gaddr),
        .ale_count_out(gcnt), .wdata_out(gwd));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One transfer: handshake, pins while selected, latency, far-side view
    task automatic xfer(input logic w, input logic [25:0] a,
                        input logic [7:0] d, input logic [1:0] sel);
        int n;
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        n = 0;
        @(negedge clk);
        while (ready !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(ready, 1'b1);
        @(posedge clk);
        valid <= 1'b0;
        n = 1;
        @(negedge clk);
        check(sel_n, sel);
        check({ale_n, dir, pack}, {1'b0, a[1], a[0]});
        while (rsp !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        check(n - 1, 18);
        check(sel_n, SEL_IDLE_N);
        check(gcnt, 3);
        check(gaddr, a[25:2]);
        if (w)
            check(gwd, d);
        else if (!a[25])
            check(rdata, a[9:2] ^ 8'h5a);
    endtask

    task automatic reset_state();
        check({sel_n, ale_n, oe, rd_n, wr_n}, {SEL_IDLE_N, 4'hb});
        check(gaddr, 0);
    endtask

    task automatic flash_write();
        xfer(1'b1, 26'h1234567, 8'ha5, SEL_FLASH_N);
    endtask

    task automatic flash_read_top();
        xfer(1'b0, 26'h1ffffff, 8'h00, SEL_FLASH_N);
    endtask

    task automatic upper_and_back_to_back();
        xfer(1'b1, 26'h2000002, 8'h3c, SEL_PROC_N);
        xfer(1'b0, 26'h0000001, 8'h00, SEL_FLASH_N);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        glue_rstn <= 1'b1;
        @(negedge clk);
        reset_state();
        flash_write();
        flash_read_top();
        upper_and_back_to_back();
        wrap_up();
    end

    // Four transfers take about 100 cycles; allow many times that
    initial
    begin
        #(40 * 2000);
        mismatches++;
        wrap_up();
    end
endmodule // slow_port_flash_addr_latch_bench
